// [clock_routing_pkg.sv]
// Purpose: shared constants and types for the clock input routing block
// Assumes: 32-bit APB, one aligned word per register, byte address = 4 x index
// Notes: only the bits that steer routing and power carry meaning here
package clock_routing_pkg;

    // apb address width covers the highest byte address (4 x 0x233)
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;

    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_PLL_POWER_POLARITY = 10'h010;
    localparam logic [9:0] IDX_PREDIV_RATIO = 10'h1e0;
    localparam logic [9:0] IDX_SOURCE_ROUTING = 10'h1e1;
    localparam logic [9:0] IDX_UPDATE_TRIGGER = 10'h232;
    localparam logic [9:0] IDX_ACTIVE_STATUS = 10'h233;

    // field positions
    localparam int PLL_POWER_LSB = 0;
    localparam int PLL_POWER_MSB = 1;
    localparam int PFD_POLARITY_BIT = 7;
    localparam int PREDIV_SEL_LSB = 0;
    localparam int PREDIV_SEL_MSB = 2;
    localparam int BYPASS_BIT = 0;
    localparam int SOURCE_BIT = 1;
    localparam int UPDATE_BIT = 0;

    // field encodings
    localparam logic [1:0] PLL_POWER_NORMAL = 2'h0;
    localparam logic [1:0] PLL_POWER_ASYNC_DOWN = 2'h1;
    localparam logic [2:0] PREDIV_SEL_MAX = 3'h4;
    localparam logic [2:0] PREDIV_RATIO_MIN = 3'h2;
    localparam logic [2:0] PREDIV_RATIO_MAX = 3'h6;

    // reset values of the staged and active bytes
    localparam logic [7:0] RST_PLL_POWER_POLARITY = 8'h01;
    localparam logic [7:0] RST_PREDIV_RATIO = 8'h02;
    localparam logic [7:0] RST_SOURCE_ROUTING = 8'h00;

    // one set of routing and power bytes, staged or active
    typedef struct packed {
        logic [7:0] pll_power_polarity;
        logic [7:0] prediv_ratio;
        logic [7:0] source_routing;
    } config_type;

    localparam config_type CONFIG_RESET = '{
        pll_power_polarity: RST_PLL_POWER_POLARITY,
        prediv_ratio: RST_PREDIV_RATIO,
        source_routing: RST_SOURCE_ROUTING
    };

endpackage

// [clock_input_routing_config.sv]
// Purpose: staged and active routing, pre-divider and pll power configuration behind apb
// Assumes: apb master on pclk, zero wait state answers, presetn asynchronous active low
// Notes: staged values reach the outputs only on an update write
//
// Operation
// - reset: pll off, external input through pre-divider
// - pll power field 01 down, 00 running
// - pre-divider select resets to 010, ratio four
// - pre-divider ratios two to six only
// - routing bits reset to external, pre-divider path
// - pll on with external: oscillator off, prescaler fed
// - update write applies programmed values
// - polarity bit: zero positive, one negative
// - reset restores defaults; rewriting defaults also works
// - bypass bit one skips the pre-divider
// - source bit one selects internal oscillator
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps

module clock_input_routing_config
    import clock_routing_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [DATA_W-1:0] prdata,
    output logic pslverr,
    output logic [1:0] pll_power_mode,
    output logic pll_enable,
    output logic pfd_polarity_negative,
    output logic [2:0] predivider_ratio,
    output logic predivider_bypass,
    output logic source_internal_osc,
    output logic internal_osc_enable,
    output logic prescaler_external_feed,
    output logic update_applied
);

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [9:0] idx);
        byte_addr = {idx, 2'h0};
    endfunction

    // pre-divider select code to ratio, out-of-range codes clamp to six
    function automatic logic [2:0] ratio_of(input logic [2:0] sel);
        logic [2:0] r;
        r = PREDIV_RATIO_MAX;
        if (sel <= PREDIV_SEL_MAX)
        begin
            r = sel + PREDIV_RATIO_MIN;
        end
        ratio_of = r;
    endfunction

    // byte lane write merge, only the low lane holds data
    function automatic logic [7:0] merge_low(input logic [7:0] old_val, input logic [DATA_W-1:0] wd,
                                             input logic [3:0] strb);
        merge_low = strb[0] ? wd[7:0] : old_val;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    // staged bytes that software programs
    config_type staged_reg;
    config_type staged_next;
    // active bytes that steer the outputs
    config_type active_reg;
    config_type active_next;
    // apb answer registers
    logic pready_reg;
    logic pready_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic pslverr_reg;
    logic pslverr_next;
    // decoded output registers
    logic [1:0] pll_power_mode_reg;
    logic [1:0] pll_power_mode_next;
    logic pll_enable_reg;
    logic pll_enable_next;
    logic pfd_neg_reg;
    logic pfd_neg_next;
    logic [2:0] ratio_reg;
    logic [2:0] ratio_next;
    logic bypass_reg;
    logic bypass_next;
    logic src_int_reg;
    logic src_int_next;
    logic osc_en_reg;
    logic osc_en_next;
    logic presc_ext_reg;
    logic presc_ext_next;
    logic update_reg;
    logic update_next;

    // bus decode terms
    logic setup_phase; // first cycle of a transfer
    logic write_commit; // write takes effect this edge
    logic addr_hit; // address maps to a register
    logic update_write; // update trigger written with bit zero set

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    always_comb
    begin
        setup_phase = psel && !penable;
        write_commit = psel && penable && pready_reg && pwrite;
        // mapped addresses only
        addr_hit = (paddr == byte_addr(IDX_PLL_POWER_POLARITY)) ||
                   (paddr == byte_addr(IDX_PREDIV_RATIO)) ||
                   (paddr == byte_addr(IDX_SOURCE_ROUTING)) ||
                   (paddr == byte_addr(IDX_UPDATE_TRIGGER)) ||
                   (paddr == byte_addr(IDX_ACTIVE_STATUS));
        // update write detected at the committing edge
        update_write = write_commit && pstrb[0] && pwdata[UPDATE_BIT] &&
                       (paddr == byte_addr(IDX_UPDATE_TRIGGER));
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: ready, read data and error one cycle after setup

    always_comb
    begin
        pready_next = setup_phase; // high through the single access cycle
        pslverr_next = setup_phase && !addr_hit;
        prdata_next = '0;
        if (setup_phase && !pwrite)
        begin
            // read mux, byte registers read zero above bit 7, status reads zero above bit 23
            if (paddr == byte_addr(IDX_PLL_POWER_POLARITY))
            begin
                prdata_next[BYTE_W-1:0] = staged_reg.pll_power_polarity;
            end
            else if (paddr == byte_addr(IDX_PREDIV_RATIO))
            begin
                prdata_next[BYTE_W-1:0] = staged_reg.prediv_ratio;
            end
            else if (paddr == byte_addr(IDX_SOURCE_ROUTING))
            begin
                prdata_next[BYTE_W-1:0] = staged_reg.source_routing;
            end
            else if (paddr == byte_addr(IDX_ACTIVE_STATUS))
            begin
                // live state: active power, ratio and routing
                prdata_next[$bits(config_type)-1:0] = active_reg;
            end
            else
            begin
                // update trigger and unmapped read as zero
                prdata_next = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // staged registers: software writes land here first

    always_comb
    begin
        staged_next = staged_reg;
        if (write_commit)
        begin
            if (paddr == byte_addr(IDX_PLL_POWER_POLARITY))
            begin
                // power field and polarity bit held until update
                staged_next.pll_power_polarity = merge_low(staged_reg.pll_power_polarity, pwdata, pstrb);
            end
            else if (paddr == byte_addr(IDX_PREDIV_RATIO))
            begin
                staged_next.prediv_ratio = merge_low(staged_reg.prediv_ratio, pwdata, pstrb);
            end
            else if (paddr == byte_addr(IDX_SOURCE_ROUTING))
            begin
                // rewriting the default bytes restores default routing
                staged_next.source_routing = merge_low(staged_reg.source_routing, pwdata, pstrb);
            end
            else
            begin
                // other addresses leave the staged set alone
                staged_next = staged_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // active registers: whole staged set copied at once on update

    always_comb
    begin
        active_next = active_reg;
        update_next = 1'b0;
        if (update_write)
        begin
            active_next = staged_reg;
            update_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output decode from the next active set, so outputs leave flops

    always_comb
    begin
        pll_power_mode_next = active_next.pll_power_polarity[PLL_POWER_MSB:PLL_POWER_LSB];
        // only 00 runs the pll, 01 and other codes keep it down
        pll_enable_next = (pll_power_mode_next == PLL_POWER_NORMAL);
        pfd_neg_next = active_next.pll_power_polarity[PFD_POLARITY_BIT];
        ratio_next = ratio_of(active_next.prediv_ratio[PREDIV_SEL_MSB:PREDIV_SEL_LSB]);
        bypass_next = active_next.source_routing[BYPASS_BIT];
        src_int_next = active_next.source_routing[SOURCE_BIT];
        // external source: internal oscillator stays off
        osc_en_next = src_int_next;
        // pll running on external input feeds the prescaler directly
        presc_ext_next = pll_enable_next && !src_int_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; reset restores the distribution-only defaults

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            staged_reg <= CONFIG_RESET;
            active_reg <= CONFIG_RESET;
            pready_reg <= 1'b0;
            prdata_reg <= '0;
            pslverr_reg <= 1'b0;
            pll_power_mode_reg <= PLL_POWER_ASYNC_DOWN;
            pll_enable_reg <= 1'b0;
            pfd_neg_reg <= 1'b0;
            ratio_reg <= ratio_of(RST_PREDIV_RATIO[PREDIV_SEL_MSB:PREDIV_SEL_LSB]);
            bypass_reg <= 1'b0;
            src_int_reg <= 1'b0;
            osc_en_reg <= 1'b0;
            presc_ext_reg <= 1'b0;
            update_reg <= 1'b0;
        end
        else
        begin
            staged_reg <= staged_next;
            active_reg <= active_next;
            pready_reg <= pready_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
            pll_power_mode_reg <= pll_power_mode_next;
            pll_enable_reg <= pll_enable_next;
            pfd_neg_reg <= pfd_neg_next;
            ratio_reg <= ratio_next;
            bypass_reg <= bypass_next;
            src_int_reg <= src_int_next;
            osc_en_reg <= osc_en_next;
            presc_ext_reg <= presc_ext_next;
            update_reg <= update_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output wiring, every output straight from a flop

    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;
    assign pll_power_mode = pll_power_mode_reg;
    assign pll_enable = pll_enable_reg;
    assign pfd_polarity_negative = pfd_neg_reg;
    assign predivider_ratio = ratio_reg;
    assign predivider_bypass = bypass_reg;
    assign source_internal_osc = src_int_reg;
    assign internal_osc_enable = osc_en_reg;
    assign prescaler_external_feed = presc_ext_reg;
    assign update_applied = update_reg;

endmodule

// [clock_routing_checker.sv]
// Purpose: port checks for the clock input routing block
// Assumes: one clock domain, presetn asynchronous active low
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module clock_routing_checker
    import clock_routing_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pslverr,
    input wire logic [1:0] pll_power_mode,
    input wire logic pll_enable,
    input wire logic pfd_polarity_negative,
    input wire logic [2:0] predivider_ratio,
    input wire logic predivider_bypass,
    input wire logic source_internal_osc,
    input wire logic internal_osc_enable,
    input wire logic prescaler_external_feed,
    input wire logic update_applied
);
    // update write committing at this edge
    logic upd_commit;
    assign upd_commit = psel & penable & pready & pwrite & pstrb[0] & pwdata[0] & (paddr == 12'h8c8);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
    answer_once_a: assert property (pready |=> !pready) else $error("answer longer than one cycle");
    update_pulse_a: assert property (upd_commit |=> update_applied) else $error("update pulse missing");
    pulse_cause_a: assert property (update_applied |-> $past(upd_commit)) else $error("stray update pulse");
    hold_config_a: assert property (!upd_commit |=> $stable({pll_power_mode, pfd_polarity_negative,
        predivider_ratio, predivider_bypass, source_internal_osc})) else $error("config moved");
    pll_on_a: assert property (pll_enable == (pll_power_mode == 2'h0)) else $error("pll enable wrong");
    ext_feed_a: assert property (prescaler_external_feed == (pll_enable && !source_internal_osc))
        else $error("prescaler feed wrong");
    osc_follow_a: assert property (internal_osc_enable == source_internal_osc) else $error("osc wrong");
    ratio_range_a: assert property (predivider_ratio inside {[3'h2:3'h6]}) else $error("ratio range");
    reset_default_a: assert property ($rose(presetn) |-> pll_power_mode == 2'h1 && predivider_ratio == 3'h4
        && !predivider_bypass && !source_internal_osc) else $error("reset routing wrong");
endmodule
bind clock_input_routing_config clock_routing_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pll_power_mode(pll_power_mode), .pll_enable(pll_enable),
    .pfd_polarity_negative(pfd_polarity_negative), .predivider_ratio(predivider_ratio),
    .predivider_bypass(predivider_bypass), .source_internal_osc(source_internal_osc),
    .internal_osc_enable(internal_osc_enable), .prescaler_external_feed(prescaler_external_feed),
    .update_applied(update_applied));

// [clock_routing_host.sv]
// Purpose: host software model, apb master for the routing registers
// Assumes: pready sampled at rising edges
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
module clock_routing_host
    import clock_routing_pkg::*;
(
    input wire logic pclk,
    input wire logic pready,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [DATA_W-1:0] pwdata,
    output logic [3:0] pstrb
);
    // idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end
    // one transfer, bounded wait for the answer
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        input logic [3:0] s, output logic [DATA_W-1:0] rd, output logic err, output bit tmo);
        rd = '0;
        err = 1'b0;
        tmo = 1'b1;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && tmo; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                err = pslverr;
                tmo = 1'b0;
            end
        end
        // release, address and data lines no longer carry the old values
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// [tb_clock_input_routing_config.sv]
// Purpose: self-checking bench for the clock input routing block
// Assumes: 125 MHz pclk, zero wait state apb answers
// Notes: outputs checked at the falling edge after chosen transfers and after each reset release
`timescale 1ns/1ps
module tb_clock_input_routing_config
    import clock_routing_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, pll_enable, pfd_polarity_negative;
    logic predivider_bypass, source_internal_osc, internal_osc_enable, prescaler_external_feed, update_applied;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] pll_power_mode;
    logic [2:0] predivider_ratio;
    logic err;
    bit tmo;
    int mismatches = 0;
    int compares = 0;
    always #4 pclk = ~pclk;
    clock_input_routing_config uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pll_power_mode(pll_power_mode), .pll_enable(pll_enable),
        .pfd_polarity_negative(pfd_polarity_negative), .predivider_ratio(predivider_ratio),
        .predivider_bypass(predivider_bypass), .source_internal_osc(source_internal_osc),
        .internal_osc_enable(internal_osc_enable), .prescaler_external_feed(prescaler_external_feed),
        .update_applied(update_applied));
    clock_routing_host host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one access with expected error flag and read data
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [31:0] exp, input logic eerr);
        host.xfer(w, a, d, s, rd, err, tmo);
        if (tmo)
        begin
            mismatches++;
            final_report();
        end
        chk({31'h0, err}, {31'h0, eerr});
        if (!w)
            chk(rd, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hf, 32'h0, 1'b0);
    endtask
    // expected outputs from active power, divider and routing bytes
    task automatic chk_out(input logic [7:0] p, input logic [7:0] r, input logic [7:0] s, input logic u);
        logic en;
        logic [2:0] q;
        @(negedge pclk);
        en = (p[1:0] == 2'h0);
        q = (r[2:0] > 3'h4) ? 3'h6 : r[2:0] + 3'h2;
        chk(32'({pll_power_mode, pll_enable, pfd_polarity_negative, predivider_ratio, predivider_bypass,
            source_internal_osc, internal_osc_enable, prescaler_external_feed, update_applied}),
            32'({p[1:0], en, p[7], q, s[0], s[1], s[1], en & ~s[1], u}));
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk_out(8'h01, 8'h02, 8'h00, 1'b0);
        acc(1'b0, 12'h8cc, 32'h0, 4'h0, 32'h00010200, 1'b0);
        // stage pll on, negative polarity, divide by two, bypass
        wr(12'h040, 32'h80);
        wr(12'h780, 32'h00);
        wr(12'h784, 32'h01);
        chk_out(8'h01, 8'h02, 8'h00, 1'b0);
        acc(1'b0, 12'h040, 32'h0, 4'h0, 32'h80, 1'b0);
        wr(12'h8c8, 32'h00);
        chk_out(8'h01, 8'h02, 8'h00, 1'b0);
        wr(12'h8c8, 32'h01);
        chk_out(8'h80, 8'h00, 8'h01, 1'b1);
        // update trigger reads zero, status shows the whole active set
        acc(1'b0, 12'h8c8, 32'h0, 4'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h8cc, 32'h0, 4'h0, 32'h00800001, 1'b0);
        // every divider code with the internal oscillator selected
        for (int c = 0; c < 8; c++)
        begin
            wr(12'h780, 32'(c));
            wr(12'h784, 32'h02);
            wr(12'h8c8, 32'h01);
            chk_out(8'h80, 8'(c), 8'h02, 1'b1);
        end
        // masked write ignored, unmapped place refused
        acc(1'b1, 12'h040, 32'h01, 4'h0, 32'h0, 1'b0);
        acc(1'b0, 12'h040, 32'h0, 4'h0, 32'h80, 1'b0);
        acc(1'b1, 12'h100, 32'h01, 4'hf, 32'h0, 1'b1);
        acc(1'b0, 12'h100, 32'h0, 4'h0, 32'h0, 1'b1);
        // defaults written back by software
        wr(12'h040, 32'h01);
        wr(12'h780, 32'h02);
        wr(12'h784, 32'h00);
        wr(12'h8c8, 32'h01);
        chk_out(8'h01, 8'h02, 8'h00, 1'b1);
        // reset in mid-run after pll was turned on
        wr(12'h040, 32'h00);
        wr(12'h8c8, 32'h01);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk_out(8'h01, 8'h02, 8'h00, 1'b0);
        acc(1'b0, 12'h040, 32'h0, 4'h0, 32'h01, 1'b0);
        final_report();
    end
endmodule
